// File: hdl/fpmc_params.svh
/*
 * fpmc_params.svh: register offsets, field values, reset values and timing
 * figures of the front panel menu controller.
 * assumes: included by bare name; definitions only.
 */
`ifndef FPMC_PARAMS_SVH
`define FPMC_PARAMS_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define FPMC_REG_GAIN 8'h00
`define FPMC_REG_SET 8'h04
`define FPMC_REG_STAT 8'h08
`define FPMC_REG_CTRL 8'h0c
`define FPMC_CTRL_LOCK_BIT 0

// ****************************************
// setting limits and encodings
// ****************************************
`define FPMC_GAIN_MIN 9'h032
`define FPMC_GAIN_MAX 9'h15e
`define FPMC_GAIN_DEF 9'h0c8
`define FPMC_GAIN_STEP_10DB 9'h014
`define FPMC_GAIN_STEP_1DB 9'h002
`define FPMC_GAIN_STEP_HALF 9'h001
`define FPMC_OFS_LIM 12'h7d0
`define FPMC_OFS_STEP_1000 12'h3e8
`define FPMC_OFS_STEP_100 12'h064
`define FPMC_OFS_STEP_10 12'h00a
`define FPMC_OFS_STEP_1 12'h001
`define FPMC_ADDR_MAX 5'h1f
`define FPMC_REF_INT 2'h0
`define FPMC_REF_EXT 2'h1
`define FPMC_REF_AUTO 2'h2
`define FPMC_IFACE_LAST 2'h2

// ****************************************
// timing
// ****************************************
`define FPMC_CLK_PERIOD_NS 4
`define FPMC_CYC_PER_MS (1000000 / `FPMC_CLK_PERIOD_NS)
`define FPMC_TIMEOUT_S 30
`define FPMC_TIMEOUT_MS (`FPMC_TIMEOUT_S * 1000)
`define FPMC_DEBOUNCE_MS 10
`define FPMC_STAGE_MS 1500

`endif

// File: hdl/fpmc_pkg.sv
/*
 * fpmc_pkg.sv: types of the front panel menu controller.
 * assumes: compiled before the controller.
 */
package fpmc_pkg;

	typedef enum logic [2:0] {FPMC_ST_LAMP, FPMC_ST_VER, FPMC_ST_NORM, FPMC_ST_MENU,
		FPMC_ST_SAVE} fpmc_state_t;

	typedef enum logic [2:0] {FPMC_M_GAIN, FPMC_M_MUTE, FPMC_M_REFMODE, FPMC_M_OFFSET,
		FPMC_M_REMOTE, FPMC_M_IFACE, FPMC_M_ADDR} fpmc_menu_t;

	// one full set of operator settings, 32 bits
	typedef struct packed {
		logic [8:0] gain;
		logic mute;
		logic [1:0] ref_mode;
		logic signed [11:0] offset;
		logic remote;
		logic [1:0] iface;
		logic [4:0] addr;
	} fpmc_set_t;

	// what the lcd shows
	typedef struct packed {
		fpmc_state_t screen;
		fpmc_menu_t menu;
		logic [2:0] cursor;
		logic ref_ext;
	} fpmc_disp_t;

	// debounced switch presses, one bit each
	typedef struct packed {
		logic menu;
		logic left;
		logic right;
		logic up;
		logic down;
	} fpmc_sw_t;

endpackage : fpmc_pkg

// File: hdl/fpmc_top.sv
/*
 * fpmc_top.sv: front panel menu controller: switches, menus, save prompt,
 * power-up screens, alarm and reference selection, register port.
 * assumes: switch, pll and reference level pins are asynchronous; the
 * non-volatile store is on clk and presents its contents on nv_rdata.
 */
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "fpmc_params.svh"

module fpmc_top
	import fpmc_pkg::*;
#(
	parameter int N_PLL = 2,
	parameter int CYC_PER_MS = `FPMC_CYC_PER_MS,
	parameter int TIMEOUT_MS = `FPMC_TIMEOUT_MS,
	parameter int DEBOUNCE_MS = `FPMC_DEBOUNCE_MS,
	parameter int STAGE_MS = `FPMC_STAGE_MS
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic menu_sw_n,
	input wire logic left_sw_n,
	input wire logic right_sw_n,
	input wire logic up_sw_n,
	input wire logic down_sw_n,
	input wire logic [N_PLL-1:0] pll_unlock,
	input wire logic ext_ref_low,
	input wire fpmc_set_t nv_rdata,
	output logic nv_wr,
	output fpmc_set_t nv_wdata,
	output fpmc_set_t act_set,
	output logic ref_sel_ext,
	output fpmc_disp_t lcd,
	output logic alarm_indicator_led,
	output logic power_indicator_led,
	output logic remote_led,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [31:0] reg_rdata
);

	// ****************************************
	// parameter checks
	// ****************************************
	if (N_PLL < 1 || CYC_PER_MS < 2 || CYC_PER_MS > 1048575) begin : g_bad_rate
		$error("fpmc_top: bad pll count or clock rate");
	end
	if (DEBOUNCE_MS < 1 || DEBOUNCE_MS > 255 || TIMEOUT_MS < 2 || TIMEOUT_MS > 65535
		|| STAGE_MS < 1 || STAGE_MS > 65535) begin : g_bad_timing
		$error("fpmc_top: bad timing parameter");
	end

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [4:0] sw1;
		logic [4:0] sw2;
		logic [4:0] stable;
		logic [4:0][7:0] db;
		fpmc_sw_t ev;
		logic [N_PLL-1:0] pll1;
		logic [N_PLL-1:0] pll2;
		logic ext1;
		logic ext2;
		logic [19:0] pre;
		logic [15:0] ms;
		fpmc_state_t st;
		fpmc_menu_t menu;
		logic [2:0] cur;
		fpmc_set_t saved;
		fpmc_set_t work;
		logic loaded;
		logic lock;
		logic nv_wr;
		fpmc_set_t act;
		logic refext;
		logic alarm;
		logic power;
		logic remote;
		fpmc_disp_t disp;
		logic [31:0] rdata;
	} fpmc_regs_t;

	fpmc_regs_t q;
	fpmc_regs_t d;

	// ****************************************
	// helpers
	// ****************************************
	function automatic int fpmc_step(input int v, input int st, input int lo, input int hi,
		input logic up);
		int r;
		r = up ? v + st : v - st;
		if (r > hi)
			r = hi;
		if (r < lo)
			r = lo;
		return r;
	endfunction : fpmc_step

	// cursor position of the return marker in each menu
	function automatic logic [2:0] fpmc_last_cur(input fpmc_menu_t m);
		unique case (m)
			FPMC_M_GAIN: return 3'h3;
			FPMC_M_OFFSET: return 3'h4;
			FPMC_M_ADDR: return 3'h2;
			default: return 3'h1;
		endcase
	endfunction : fpmc_last_cur

	// a corrupt store must not bring up an out-of-range setting
	function automatic fpmc_set_t fpmc_fix(input fpmc_set_t s);
		fpmc_set_t r;
		r = s;
		if (s.gain < `FPMC_GAIN_MIN || s.gain > `FPMC_GAIN_MAX)
			r.gain = `FPMC_GAIN_DEF;
		if (s.offset > $signed(`FPMC_OFS_LIM) || s.offset < -$signed(`FPMC_OFS_LIM))
			r.offset = 12'h000;
		if (s.ref_mode > `FPMC_REF_AUTO)
			r.ref_mode = `FPMC_REF_INT;
		if (s.iface > `FPMC_IFACE_LAST)
			r.iface = 2'h0;
		return r;
	endfunction : fpmc_fix

	// ****************************************
	// next state
	// ****************************************
	logic tick;
	logic editing;
	fpmc_set_t act;

	always_comb begin
		d = q;
		tick = (q.pre == 20'(CYC_PER_MS - 1));
		d.pre = tick ? 20'h00000 : q.pre + 20'h00001;
		d.nv_wr = 1'b0;

		// two-flop synchronisers
		d.sw1 = ~{menu_sw_n, left_sw_n, right_sw_n, up_sw_n, down_sw_n};
		d.sw2 = q.sw1;
		d.pll1 = pll_unlock;
		d.pll2 = q.pll1;
		d.ext1 = ext_ref_low;
		d.ext2 = q.ext1;

		// debounce: level must hold DEBOUNCE_MS before it counts
		for (int i = 0; i < 5; i++) begin
			if (q.sw2[i] == q.stable[i]) begin
				d.db[i] = 8'h00;
			end else if (tick) begin
				if (q.db[i] == 8'(DEBOUNCE_MS - 1)) begin
					d.stable[i] = q.sw2[i];
					d.db[i] = 8'h00;
				end else begin
					d.db[i] = q.db[i] + 8'h01;
				end
			end
		end
		d.ev = fpmc_sw_t'(d.stable & ~q.stable & {5{~q.lock}});

		// first cycle after reset: take the stored settings
		if (!q.loaded) begin
			d.saved = fpmc_fix(nv_rdata);
			d.loaded = 1'b1;
		end

		unique case (q.st)
			FPMC_ST_LAMP, FPMC_ST_VER: begin
				if (tick) begin
					if (q.ms == 16'(STAGE_MS - 1)) begin
						d.ms = 16'h0000;
						d.st = (q.st == FPMC_ST_LAMP) ? FPMC_ST_VER : FPMC_ST_NORM;
					end else begin
						d.ms = q.ms + 16'h0001;
					end
				end
			end
			FPMC_ST_NORM: begin
				if (q.ev.menu) begin
					d.st = FPMC_ST_MENU;
					d.menu = FPMC_M_GAIN;
					d.cur = 3'h0;
					d.work = q.saved;
					d.ms = 16'h0000;
				end
			end
			FPMC_ST_MENU, FPMC_ST_SAVE: begin
				if (q.ev != '0)
					d.ms = 16'h0000;
				else if (tick)
					d.ms = q.ms + 16'h0001;
				if (q.ev.left && q.cur != 3'h0)
					d.cur = q.cur - 3'h1;
				if (q.ev.right && q.cur != (q.st == FPMC_ST_SAVE ? 3'h1 : fpmc_last_cur(q.menu)))
					d.cur = q.cur + 3'h1;
				if (q.st == FPMC_ST_MENU && (q.ev.up || q.ev.down)
					&& q.cur != fpmc_last_cur(q.menu)) begin
					unique case (q.menu)
						FPMC_M_GAIN:
							d.work.gain = 9'(fpmc_step(int'(q.work.gain),
								q.cur == 3'h0 ? int'(`FPMC_GAIN_STEP_10DB) :
								q.cur == 3'h1 ? int'(`FPMC_GAIN_STEP_1DB) :
								int'(`FPMC_GAIN_STEP_HALF), int'(`FPMC_GAIN_MIN),
								int'(`FPMC_GAIN_MAX), q.ev.up));
						FPMC_M_MUTE:
							d.work.mute = ~q.work.mute;
						FPMC_M_REMOTE:
							d.work.remote = ~q.work.remote;
						FPMC_M_REFMODE:
							d.work.ref_mode = q.ev.up ?
								(q.work.ref_mode == `FPMC_REF_AUTO ? `FPMC_REF_INT :
								q.work.ref_mode + 2'h1) :
								(q.work.ref_mode == `FPMC_REF_INT ? `FPMC_REF_AUTO :
								q.work.ref_mode - 2'h1);
						FPMC_M_IFACE:
							d.work.iface = q.ev.up ?
								(q.work.iface == `FPMC_IFACE_LAST ? 2'h0 : q.work.iface + 2'h1) :
								(q.work.iface == 2'h0 ? `FPMC_IFACE_LAST : q.work.iface - 2'h1);
						FPMC_M_OFFSET:
							d.work.offset = 12'(fpmc_step(int'(q.work.offset),
								q.cur == 3'h0 ? int'(`FPMC_OFS_STEP_1000) :
								q.cur == 3'h1 ? int'(`FPMC_OFS_STEP_100) :
								q.cur == 3'h2 ? int'(`FPMC_OFS_STEP_10) :
								int'(`FPMC_OFS_STEP_1), -int'(`FPMC_OFS_LIM),
								int'(`FPMC_OFS_LIM), q.ev.up));
						FPMC_M_ADDR:
							d.work.addr = 5'(fpmc_step(int'(q.work.addr), q.cur == 3'h0 ? 10 : 1,
								0, int'(`FPMC_ADDR_MAX), q.ev.up));
					endcase
				end
				if (q.ev.menu) begin
					d.cur = 3'h0;
					if (q.st == FPMC_ST_SAVE) begin
						d.st = FPMC_ST_NORM;
						if (q.cur == 3'h0) begin
							d.saved = q.work;
							d.nv_wr = 1'b1;
						end
					end else if (q.cur == fpmc_last_cur(q.menu) || q.menu == FPMC_M_ADDR) begin
						d.st = FPMC_ST_SAVE;
					end else begin
						d.menu = fpmc_menu_t'(q.menu + 3'h1);
					end
				end else if (tick && q.ms == 16'(TIMEOUT_MS - 1)) begin
					d.st = FPMC_ST_NORM;
				end
			end
			default: d.st = FPMC_ST_NORM;
		endcase

		// gain under edit reaches the signal path at once; the rest waits for yes
		editing = (q.st == FPMC_ST_MENU || q.st == FPMC_ST_SAVE);
		act = q.saved;
		if (editing)
			act.gain = q.work.gain;
		d.act = act;
		d.refext = (q.saved.ref_mode == `FPMC_REF_EXT)
			|| (q.saved.ref_mode == `FPMC_REF_AUTO && !q.ext2);
		d.alarm = |q.pll2;
		d.remote = q.saved.remote;
		d.power = 1'b1;
		d.disp.screen = q.st;
		d.disp.menu = q.menu;
		d.disp.cursor = q.cur;
		d.disp.ref_ext = q.refext;

		// register port
		if (reg_we && reg_addr == `FPMC_REG_CTRL)
			d.lock = reg_wdata[`FPMC_CTRL_LOCK_BIT];
		d.rdata = 32'h00000000;
		if (reg_re) begin
			unique case (reg_addr)
				`FPMC_REG_GAIN: d.rdata = {23'h000000, q.act.gain};
				`FPMC_REG_SET: d.rdata = q.saved;
				`FPMC_REG_STAT: d.rdata = {20'h00000, q.st, q.menu, q.cur, q.refext, q.alarm,
					editing};
				`FPMC_REG_CTRL: d.rdata = {31'h00000000, q.lock};
				default: d.rdata = 32'h00000000;
			endcase
		end
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			q <= '0;
			q.st <= FPMC_ST_LAMP;
			q.menu <= FPMC_M_GAIN;
			q.saved.gain <= `FPMC_GAIN_DEF;
			q.work.gain <= `FPMC_GAIN_DEF;
			q.act.gain <= `FPMC_GAIN_DEF;
		end else begin
			q <= d;
		end
	end

	assign nv_wr = q.nv_wr;
	assign nv_wdata = q.saved;
	assign act_set = q.act;
	assign ref_sel_ext = q.refext;
	assign lcd = q.disp;
	assign alarm_indicator_led = q.alarm;
	assign power_indicator_led = q.power;
	assign remote_led = q.remote;
	assign reg_rdata = q.rdata;

	// ****************************************
	// checks
	// ****************************************
	a_gain_range: assert property (@(posedge clk) disable iff (sys_rst)
		q.loaded |-> (act_set.gain >= `FPMC_GAIN_MIN && act_set.gain <= `FPMC_GAIN_MAX))
		else $error("gain outside 5.0..35.0 dB");

	a_offset_range: assert property (@(posedge clk) disable iff (sys_rst)
		q.work.offset <= $signed(`FPMC_OFS_LIM) && q.work.offset >= -$signed(`FPMC_OFS_LIM))
		else $error("offset outside limits");

	a_alarm_follow: assert property (@(posedge clk) disable iff (sys_rst)
		q.loaded |-> alarm_indicator_led == (|$past(q.pll2)))
		else $error("alarm does not follow pll unlock");

	a_remote_led: assert property (@(posedge clk) disable iff (sys_rst)
		q.loaded |=> remote_led == $past(q.saved.remote))
		else $error("remote led does not follow remote mode");

	a_ref_select: assert property (@(posedge clk) disable iff (sys_rst)
		(q.saved.ref_mode == `FPMC_REF_AUTO && q.ext2 && $stable(q.saved.ref_mode))
		|=> !ref_sel_ext)
		else $error("auto mode kept a weak external reference");

	a_save_commit: assert property (@(posedge clk) disable iff (sys_rst)
		(q.st == FPMC_ST_SAVE && q.ev.menu && q.cur == 3'h0)
		|=> nv_wr && nv_wdata == $past(q.work) ##1 !nv_wr)
		else $error("yes did not commit settings");

	a_no_commit: assert property (@(posedge clk) disable iff (sys_rst)
		(q.loaded && !(q.st == FPMC_ST_SAVE && q.ev.menu && q.cur == 3'h0))
		|=> $stable(q.saved) && !nv_wr)
		else $error("settings changed without yes");

	a_timeout_exit: assert property (@(posedge clk) disable iff (sys_rst)
		(q.st == FPMC_ST_MENU && tick && q.ms == 16'(TIMEOUT_MS - 1) && q.ev == '0)
		|=> q.st == FPMC_ST_NORM ##1 act_set.gain == q.saved.gain)
		else $error("idle editing not abandoned");

	a_menu_order: assert property (@(posedge clk) disable iff (sys_rst)
		(q.st == FPMC_ST_MENU && q.ev.menu && q.menu != FPMC_M_ADDR
		&& q.cur != fpmc_last_cur(q.menu)) |=> q.menu == fpmc_menu_t'($past(q.menu) + 3'h1))
		else $error("menu order broken");

	a_toggle: assert property (@(posedge clk) disable iff (sys_rst)
		(q.st == FPMC_ST_MENU && q.menu == FPMC_M_MUTE && q.cur == 3'h0
		&& (q.ev.up || q.ev.down)) |=> q.work.mute != $past(q.work.mute))
		else $error("on/off item did not toggle");

	a_power_seq: assert property (@(posedge clk) disable iff (sys_rst)
		q.st == FPMC_ST_LAMP |=> q.st == FPMC_ST_LAMP || q.st == FPMC_ST_VER)
		else $error("power-up screens out of order");

endmodule : fpmc_top
`default_nettype wire

// File: testbench/fpmc_nv_model.sv
/*
 * fpmc_nv_model.sv: behavioural non-volatile settings store at the far side.
 * assumes: written on the controller clock by a one-cycle nv_wr pulse.
 */
`timescale 1ns/1ns
`default_nettype none

module fpmc_nv_model
	import fpmc_pkg::*;
#(
	parameter fpmc_set_t INIT = '0
) (
	input wire logic clk,
	input wire logic nv_wr,
	input wire fpmc_set_t nv_wdata,
	output var fpmc_set_t nv_rdata,
	output var int n_wr
);
	// ****************************************
	// storage
	// ****************************************
	// no reset input on purpose: contents must outlive a power cycle
	initial begin
		nv_rdata = INIT;
		n_wr = 0;
	end

	always @(posedge clk) begin
		if (nv_wr) begin
			nv_rdata <= nv_wdata;
			n_wr <= n_wr + 1;
		end
	end
endmodule : fpmc_nv_model

`default_nettype wire

// File: testbench/tb_front_panel_menu_controller.sv
/*
 * tb_front_panel_menu_controller.sv: self-checking bench of the panel controller.
 * assumes: shortened ms tick, debounce, stage and idle counts; nv store model.
 */
`timescale 1ns/1ns
`default_nettype none
`include "fpmc_params.svh"

module tb_front_panel_menu_controller import fpmc_pkg::*;;
	// ****************************************
	// signals
	// ****************************************
	localparam fpmc_set_t INIT = '{gain: 9'h154, mute: 1'b0, ref_mode: `FPMC_REF_AUTO,
		offset: 12'h000, remote: 1'b0, iface: 2'h1, addr: 5'h05};
	localparam int SM = 4, SL = 3, SR = 2, SU = 1, SD = 0;
	logic clk, sys_rst, ext_ref_low, nv_wr, reg_we, reg_re, ref_sel_ext;
	logic alarm_indicator_led, power_indicator_led, remote_led;
	logic [4:0] sw_n;
	logic [1:0] pll_unlock;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic [8:0] g;
	fpmc_set_t nv_rdata, nv_wdata, act_set, exp_set;
	fpmc_disp_t lcd;
	int n_fail, checks_done, n_wr;
	logic seen_ver;

	fpmc_top #(.N_PLL(2), .CYC_PER_MS(4), .TIMEOUT_MS(20), .DEBOUNCE_MS(2), .STAGE_MS(3)) u_dut (
		.clk(clk), .sys_rst(sys_rst), .menu_sw_n(sw_n[SM]), .left_sw_n(sw_n[SL]),
		.right_sw_n(sw_n[SR]), .up_sw_n(sw_n[SU]), .down_sw_n(sw_n[SD]),
		.pll_unlock(pll_unlock), .ext_ref_low(ext_ref_low), .nv_rdata(nv_rdata),
		.nv_wr(nv_wr), .nv_wdata(nv_wdata), .act_set(act_set), .ref_sel_ext(ref_sel_ext),
		.lcd(lcd), .alarm_indicator_led(alarm_indicator_led),
		.power_indicator_led(power_indicator_led), .remote_led(remote_led),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
		.reg_rdata(reg_rdata));

	fpmc_nv_model #(.INIT(INIT)) u_nv (.clk(clk), .nv_wr(nv_wr), .nv_wdata(nv_wdata),
		.nv_rdata(nv_rdata), .n_wr(n_wr));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// ****************************************
	// helpers
	// ****************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic summarize;
		if (n_fail == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : summarize

	// hold and release well past the debounce so one press is one action
	task automatic press(input int k);
		@(posedge clk);
		sw_n[k] <= 1'b0;
		repeat (20) @(posedge clk);
		sw_n[k] <= 1'b1;
		repeat (20) @(posedge clk);
		@(negedge clk);
	endtask : press

	task automatic nw(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask : nw

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_we <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_we <= 1'b0;
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_re <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_re <= 1'b0;
		@(negedge clk);
		chk(reg_rdata, e);
	endtask : rdc

	function automatic logic [8:0] gadd(input int v, input int d);
		int s;
		s = v + d;
		if (s > `FPMC_GAIN_MAX) s = `FPMC_GAIN_MAX;
		if (s < `FPMC_GAIN_MIN) s = `FPMC_GAIN_MIN;
		return s[8:0];
	endfunction : gadd

	function automatic int cadd(input int v, input int d, input int lo, input int hi);
		int s;
		s = v + d;
		if (s > hi) s = hi;
		if (s < lo) s = lo;
		return s;
	endfunction : cadd

	// ****************************************
	// watchdog
	// ****************************************
	initial begin
		repeat (5000) @(posedge clk);
		n_fail++;
		summarize();
	end

	// ****************************************
	// tests
	// ****************************************
	initial begin
		sw_n = 5'h1f;
		sys_rst = 1'b1;
		pll_unlock = 2'h0;
		ext_ref_low = 1'b0;
		reg_we = 1'b0;
		reg_re = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		n_fail = 0;
		checks_done = 0;
		seen_ver = 1'b0;
		void'($urandom(32'h0aaff292));
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		nw(2);
		chk(lcd.screen, FPMC_ST_LAMP);
		repeat (60) begin
			@(negedge clk);
			if (lcd.screen === FPMC_ST_VER) seen_ver = 1'b1;
		end
		chk(seen_ver, 1'b1);
		chk(lcd.screen, FPMC_ST_NORM);
		chk(act_set, INIT);
		chk(power_indicator_led, 1'b1);
		chk(ref_sel_ext, 1'b1);
		chk(lcd.ref_ext, 1'b1);
		@(posedge clk) ext_ref_low <= 1'b1;
		nw(6);
		chk(ref_sel_ext, 1'b0);
		chk(lcd.ref_ext, 1'b0);
		@(posedge clk) ext_ref_low <= 1'b0;
		@(posedge clk) pll_unlock <= 2'h1 << $urandom_range(1, 0);
		nw(6);
		chk(alarm_indicator_led, 1'b1);
		@(posedge clk) pll_unlock <= 2'h0;
		nw(6);
		chk(alarm_indicator_led, 1'b0);
		rdc(8'h00, {23'h0, INIT.gain});
		wr(8'h04, $urandom());
		rdc(8'h04, INIT);
		rdc(8'h10, 32'h0);
		wr(8'h0c, 32'h1);
		rdc(8'h0c, 32'h1);
		press(SM);
		chk(lcd.screen, FPMC_ST_NORM);
		wr(8'h0c, 32'h0);
		// live gain edit abandoned by idling
		press(SM);
		chk(lcd.menu, FPMC_M_GAIN);
		press(SU);
		g = gadd(INIT.gain, 20);
		chk(act_set.gain, g);
		chk(nv_wdata.gain, INIT.gain);
		press(SR);
		chk(lcd.cursor, 3'h1);
		press(SD);
		g = gadd(g, -2);
		chk(act_set.gain, g);
		press(SR);
		press(SD);
		g = gadd(g, -1);
		chk(act_set.gain, g);
		press(SL);
		chk(lcd.cursor, 3'h1);
		nw(140);
		chk(lcd.screen, FPMC_ST_NORM);
		chk(act_set.gain, INIT.gain);
		// return marker to save prompt, answer no
		press(SM);
		press(SU);
		repeat (3) press(SR);
		chk(lcd.cursor, 3'h3);
		press(SM);
		chk(lcd.screen, FPMC_ST_SAVE);
		press(SR);
		press(SM);
		chk(act_set.gain, INIT.gain);
		chk(n_wr, 0);
		// full walk through the menus, answer yes
		press(SM);
		for (int i = 0; i < 7; i++) begin
			chk(lcd.menu, i);
			if (i == 1 || i == 2 || i == 5 || i == 6) press(SU);
			if (i == 4) press(SD);
			if (i == 3) repeat (3) press(SD);
			press(SM);
		end
		chk(lcd.screen, FPMC_ST_SAVE);
		press(SM);
		exp_set = INIT;
		exp_set.mute = 1'b1;
		exp_set.ref_mode = `FPMC_REF_INT;
		exp_set.remote = 1'b1;
		repeat (3) exp_set.offset = 12'(cadd(int'(exp_set.offset), -1000, -2000, 2000));
		exp_set.iface = 2'h2;
		exp_set.addr = 5'(cadd(int'(INIT.addr), 10, 0, 31));
		chk(nv_rdata, exp_set);
		chk(act_set, exp_set);
		chk(n_wr, 1);
		chk(remote_led, 1'b1);
		chk(ref_sel_ext, 1'b0);
		// power cycle: committed settings must come back from the store
		@(posedge clk) sys_rst <= 1'b1;
		repeat (11) @(posedge clk);
		@(negedge clk);
		chk(power_indicator_led, 1'b0);
		@(posedge clk) sys_rst <= 1'b0;
		nw(60);
		chk(lcd.screen, FPMC_ST_NORM);
		chk(act_set, exp_set);
		chk(remote_led, 1'b1);
		chk(n_wr, 1);
		summarize();
	end
endmodule : tb_front_panel_menu_controller

`default_nettype wire
